//--- ssb_core.sv
/*
 * Status flags, double-buffered data and shifter of the serial port.
 * Assumes a classic Wishbone master on CLK; SCK, MISO and SS_N are
 * asynchronous pins sampled on CLK.
 */
// The placing of the registers and the Wishbone register port were left to the implementer.
//
// Summary of operation
// - Transfer done sets receive-full, status bit 7
// - Receive-full clears after status read, data read
// - Transmit-empty shows transmit buffer has room
// - Transmit-empty clears by status read, data write
// - Data write ignored without armed status read
// - Transmit interrupt when empty and enabled
// - Buffer to shifter move sets transmit-empty
// - Idle master write moves to shifter within two cycles
// - Shifter done loads queued byte, else nothing
// - Master with select low sets mode-fault
// - Mode-fault only when master, fault on, no output
// - Mode-fault clears by read, then control write
// - Data read gives receive, write loads transmit
// - Master starts transfer on buffered write
// - Unread receive byte kept, new byte dropped
// - Unused status bits read zero, writes ignored
// - Eight serial clocks complete one transfer
`timescale 1ns/100ps
`default_nettype none
module ssb_core
    import ssb_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        SCK,
    input  wire logic        MISO,
    input  wire logic        SS_N,
    output logic             MOSI,
    output logic             IRQ
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    ssb_pins_type pin_meta_ff;
    ssb_pins_type pin_sync_ff;
    logic         sck_last_ff;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            // Idle pin levels, so no false edge follows reset
            pin_meta_ff <= '{sck: 1'b0, miso: 1'b0, ss_n: 1'b1};
            pin_sync_ff <= '{sck: 1'b0, miso: 1'b0, ss_n: 1'b1};
            sck_last_ff <= 1'b0;
        end
        else
        begin
            pin_meta_ff <= '{sck: SCK, miso: MISO, ss_n: SS_N};
            pin_sync_ff <= pin_meta_ff;
            sck_last_ff <= pin_sync_ff.sck;
        end
    end

    wire logic sck_rise = pin_sync_ff.sck & ~sck_last_ff;
    wire logic sck_fall = ~pin_sync_ff.sck & sck_last_ff;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [31:0] adr,
                                 input logic [3:0]  idx);
        hit = (adr[ADR_LSB+3:ADR_LSB] == idx) &&
              (adr[31:ADR_LSB+4] == '0);
    endfunction

    logic       ack_ff;
    wire logic  req     = WB_CYC_I & WB_STB_I & ~ack_ff;
    wire logic  lane0   = WB_SEL_I[0];
    wire logic  rd_st   = req & ~WB_WE_I & hit(WB_ADR_I, ADR_STATUS);
    wire logic  rd_data = req & ~WB_WE_I & hit(WB_ADR_I, ADR_DATA);

    wire logic  wr_data = req & WB_WE_I & lane0 & hit(WB_ADR_I, ADR_DATA);
    wire logic  wr_c1   = req & WB_WE_I & lane0 & hit(WB_ADR_I, ADR_CTRL1);
    wire logic  wr_ist  = req & WB_WE_I & lane0 & hit(WB_ADR_I, ADR_IRQ_ST);
    wire logic  wr_imsk = req & WB_WE_I & lane0
                          & hit(WB_ADR_I, ADR_IRQ_MSK);

    // ---------------------------------------------------------------
    // State declarations
    // ---------------------------------------------------------------
    logic [7:0]     ctrl1_ff;
    logic [7:0]     tx_buf_ff;
    logic           tx_full_ff;

    logic [7:0]     rx_buf_ff;
    logic           rxf_ff;
    logic           mode_fault_flag_ff;

    logic           rxf_arm_ff;
    logic           txe_arm_ff;
    logic           mode_fault_flag_arm_ff;
    logic [7:0]     shift_ff;
    logic [3:0]     bit_cnt_ff;
    ssb_shift_type  sh_state_ff;

    logic [EV_W-1:0] ev_st_ff;
    logic [EV_W-1:0] ev_msk_ff;

    wire logic txe     = ~tx_full_ff;
    wire logic is_master_select = ctrl1_ff[C1_MASTER_SELECT];
    wire logic fault_in = is_master_select & ctrl1_ff[C1_FEN]
                          & ~ctrl1_ff[C1_SELECT_OUTPUT_ENABLE];

    wire logic wr_ok   = wr_data & txe_arm_ff;
    wire logic done    = (sh_state_ff == SH_RUN) && sck_fall
                         && (bit_cnt_ff == BITS_BYTE);
    wire logic load    = (sh_state_ff == SH_LOAD)
                         || (done && tx_full_ff);

    // ---------------------------------------------------------------
    // Control register one
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ctrl1_ff <= CTRL1_RST;
        else if (wr_c1)
            ctrl1_ff <= WB_DAT_I[7:0];
    end

    // ---------------------------------------------------------------
    // Transmit buffer and empty flag
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            tx_buf_ff  <= BYTE_ZERO;
            tx_full_ff <= 1'b0;
        end
        else if (wr_ok)
        begin
            tx_buf_ff  <= WB_DAT_I[7:0];
            tx_full_ff <= 1'b1;
        end
        else if (load)
            tx_full_ff <= 1'b0;
    end

    // Arming is lost on any data write so each byte needs a fresh read
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            txe_arm_ff <= 1'b0;
        else if (rd_st)
            txe_arm_ff <= txe;
        else if (wr_data)
            txe_arm_ff <= 1'b0;
    end

    // ---------------------------------------------------------------
    // Shifter
    // ---------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sh_state_ff <= SH_IDLE;
            shift_ff    <= BYTE_ZERO;
            bit_cnt_ff  <= BIT_ZERO;
        end
        else
        begin
            unique case (sh_state_ff)
                SH_IDLE:
                begin
                    // Only a master launches from its own write
                    if (tx_full_ff && is_master_select)
                        sh_state_ff <= SH_LOAD;
                end
                SH_LOAD:
                begin
                    shift_ff    <= tx_buf_ff;
                    bit_cnt_ff  <= BIT_ZERO;
                    sh_state_ff <= SH_RUN;
                end
                SH_RUN:
                begin
                    // Eight rises fill the byte, the closing fall ends it
                    if (sck_rise)
                    begin
                        shift_ff   <= {shift_ff[6:0], pin_sync_ff.miso};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    if (done)
                    begin
                        if (tx_full_ff)
                        begin
                            shift_ff   <= tx_buf_ff;
                            bit_cnt_ff <= BIT_ZERO;
                        end
                        else
                            sh_state_ff <= SH_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            MOSI <= 1'b0;
        else
            MOSI <= shift_ff[7];
    end

    // ---------------------------------------------------------------
    // Receive buffer and full flag
    // ---------------------------------------------------------------
    wire logic rx_take = done & ~rxf_ff;
    wire logic rxf_clr = rd_data & rxf_arm_ff;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rx_buf_ff <= BYTE_ZERO;
            rxf_ff    <= 1'b0;
        end
        else
        begin
            // All eight bits are in by the last fall; no extra shift
            if (rx_take)
                rx_buf_ff <= shift_ff;
            // Set beats clear when both land together
            if (done)
                rxf_ff <= 1'b1;
            else if (rxf_clr)
                rxf_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            rxf_arm_ff <= 1'b0;
        else if (rd_st)
            rxf_arm_ff <= rxf_ff;
        else if (rd_data)
            rxf_arm_ff <= 1'b0;
    end

    // ---------------------------------------------------------------
    // Mode fault
    // ---------------------------------------------------------------
    // Level sensitive: the flag keeps re-setting while select is low
    wire logic mode_fault_flag_set = fault_in & ~pin_sync_ff.ss_n;

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            mode_fault_flag_ff     <= 1'b0;
            mode_fault_flag_arm_ff <= 1'b0;
        end
        else
        begin
            if (mode_fault_flag_set)
                mode_fault_flag_ff <= 1'b1;
            else if (wr_c1 && mode_fault_flag_arm_ff)
                mode_fault_flag_ff <= 1'b0;
            if (rd_st)
                mode_fault_flag_arm_ff <= mode_fault_flag_ff;
            else if (wr_c1)
                mode_fault_flag_arm_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Event status, mask and interrupt
    // ---------------------------------------------------------------
    // Sticky copies keep events that the live flags lose
    logic [EV_W-1:0] ev_set;

    always_comb
    begin
        ev_set          = '0;
        ev_set[EV_RX]   = done;
        ev_set[EV_TX]   = load;
        ev_set[EV_MODE_FAULT_FLAG] = mode_fault_flag_set;
        ev_set[EV_OVR]  = done & rxf_ff;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ev_st_ff <= '0;
        else if (wr_ist)
            ev_st_ff <= (ev_st_ff & ~WB_DAT_I[EV_W-1:0]) | ev_set;
        else
            ev_st_ff <= ev_st_ff | ev_set;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ev_msk_ff <= '0;
        else if (wr_imsk)
            ev_msk_ff <= WB_DAT_I[EV_W-1:0];
    end

    // Level output, one cycle behind the flags it reflects
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            IRQ <= 1'b0;
        else
            IRQ <= (txe & ctrl1_ff[C1_TIE])
                   | (|(ev_st_ff & ev_msk_ff));
    end

    // ---------------------------------------------------------------
    // Read data and acknowledge
    // ---------------------------------------------------------------
    logic [31:0] rdata;

    always_comb
    begin
        rdata = WORD_ZERO;
        if (hit(WB_ADR_I, ADR_STATUS))
        begin
            rdata[ST_RXF]  = rxf_ff;
            rdata[ST_TXE]  = txe;
            rdata[ST_MODE_FAULT_FLAG] = mode_fault_flag_ff;
        end
        else if (hit(WB_ADR_I, ADR_DATA))
            rdata[7:0] = rx_buf_ff;
        else if (hit(WB_ADR_I, ADR_CTRL1))
            rdata[7:0] = ctrl1_ff;
        else if (hit(WB_ADR_I, ADR_IRQ_ST))
            rdata[EV_W-1:0] = ev_st_ff;
        else if (hit(WB_ADR_I, ADR_IRQ_MSK))
            rdata[EV_W-1:0] = ev_msk_ff;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ack_ff   <= 1'b0;
            WB_DAT_O <= WORD_ZERO;
        end
        else
        begin
            ack_ff   <= req;
            WB_DAT_O <= req ? rdata : WORD_ZERO;
        end
    end

    assign WB_ACK_O = ack_ff;

endmodule // ssb_core
`default_nettype wire

//--- ssb_pkg.sv
/*
 * Constants and types for the serial status and data buffer block.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package ssb_pkg;
    // -------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------
    localparam logic [3:0] ADR_STATUS  = 4'h0;  // serial_status
    localparam logic [3:0] ADR_DATA    = 4'h1;  // serial_data
    localparam logic [3:0] ADR_CTRL1   = 4'h2;  // control_register_one
    localparam logic [3:0] ADR_IRQ_ST  = 4'h3;  // sticky events
    localparam logic [3:0] ADR_IRQ_MSK = 4'h4;  // event mask
    localparam int         ADR_LSB     = 2;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int ST_RXF  = 7;
    localparam int ST_TXE  = 5;
    localparam int ST_MODE_FAULT_FLAG = 4;
    localparam int C1_TIE  = 7;   // transmit_irq_enable
    localparam int C1_MASTER_SELECT = 4;   // master_select
    localparam int C1_FEN  = 1;   // fault_function_enable
    localparam int C1_SELECT_OUTPUT_ENABLE = 0;   // select_output_enable
    localparam int EV_RX   = 0;
    localparam int EV_TX   = 1;
    localparam int EV_MODE_FAULT_FLAG = 2;
    localparam int EV_OVR  = 3;
    localparam int EV_W    = 4;

    localparam logic [7:0]  CTRL1_RST  = 8'h00;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
    localparam logic [3:0]  BITS_BYTE  = 4'h8;   // Bits per transfer
    localparam logic [3:0]  BIT_ZERO   = 4'h0;

    typedef enum logic [2:0]
    {
        SH_IDLE = 3'b001,
        SH_LOAD = 3'b010,
        SH_RUN  = 3'b100
    } ssb_shift_type;

    typedef struct packed
    {
        logic       sck;
        logic       miso;
        logic       ss_n;
    } ssb_pins_type;
endpackage : ssb_pkg

//--- ssb_core_properties.sv
/* Port checker for the serial status and data buffer block.
   Bound to every ssb_core; Wishbone master keeps one idle cycle. */
`timescale 1ns/100ps
`default_nettype none
module ssb_core_properties
    import ssb_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        SS_N,
    input wire logic        IRQ
);
    // ----
    // Helpers
    // ----
    logic [7:0] ctrl_ff;
    logic [3:0] low_ff;
    logic       seen_ff;
    logic       req;
    logic       mf_en;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign mf_en = ctrl_ff[C1_MASTER_SELECT] && ctrl_ff[C1_FEN] && !ctrl_ff[C1_SELECT_OUTPUT_ENABLE];
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            ctrl_ff <= CTRL1_RST;
        else if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I[5:2] == ADR_CTRL1)
            ctrl_ff <= WB_DAT_I[7:0];
    end
    // Select low time; saturates so it never wraps back to zero
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            low_ff <= 4'h0;
        else if (!(mf_en && !SS_N))
            low_ff <= 4'h0;
        else if (low_ff != 4'hf)
            low_ff <= low_ff + 4'h1;
    end
    // Sticky on purpose: a fault flag may outlive its cause
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            seen_ff <= 1'b0;
        else if (mf_en && !SS_N)
            seen_ff <= 1'b1;
    end
    // ----
    // Properties
    // ----
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence st_read;
        req && !WB_WE_I && WB_ADR_I[5:2] == ADR_STATUS ##1 WB_ACK_O;
    endsequence
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held too long");
    ack_answer_a: assert property (req |=> WB_ACK_O)
        else $error("request not answered");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == WORD_ZERO)
        else $error("read data outside ack");
    status_unused_a: assert property (
        st_read |-> (WB_DAT_O & 32'hffff_ff4f) == WORD_ZERO)
        else $error("unused status bits set");
    tx_irq_a: assert property (
        st_read ##0 (WB_DAT_O[ST_TXE] && ctrl_ff[C1_TIE]) |-> ##[0:2] IRQ)
        else $error("transmit interrupt missing");
    mode_fault_flag_never_a: assert property (
        st_read ##0 !seen_ff |-> !WB_DAT_O[ST_MODE_FAULT_FLAG])
        else $error("mode fault while disabled");
    mode_fault_flag_set_a: assert property (
        st_read ##0 (low_ff > 4'h5) |-> WB_DAT_O[ST_MODE_FAULT_FLAG])
        else $error("mode fault not flagged");
    cover property (st_read ##0 WB_DAT_O[ST_RXF]);
    cover property (st_read ##0 WB_DAT_O[ST_MODE_FAULT_FLAG]);
    cover property (IRQ);
endmodule // ssb_core_properties
bind ssb_core ssb_core_properties ssb_core_properties_i (.CLK, .RESETN,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_SEL_I, .WB_ADR_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .SS_N, .IRQ);
`default_nettype wire

//--- ssb_slave_model.sv
/* Remote serial device: clocks bytes MSB first, records MOSI.
   Clock idles low; MISO flips after a frame, no pull. */
`timescale 1ns/100ps
`default_nettype none
module ssb_slave_model
(
    output logic      SCK,
    output logic      MISO,
    output logic      SS_N,
    input  wire logic MOSI
);
    logic [7:0] got;
    initial
    begin
        SCK = 1'b0;
        MISO = 1'b1;
        SS_N = 1'b1;
        got = 8'h00;
    end
    task automatic xfer(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--)
        begin
            MISO <= tx[i];
            #31.2;
            got[i] = MOSI;
            SCK = 1'b1;
            #62.5;
            SCK = 1'b0;
            #31.3;
        end
        MISO <= ~tx[0];
    endtask
    task automatic select(input logic lo);
        SS_N <= ~lo;
    endtask
endmodule // ssb_slave_model
`default_nettype wire

//--- tb_ssb_core.sv
/* Self-checking bench for ssb_core with a remote device model.
   Wishbone master here; model clocks the link at 125 ns. */
`timescale 1ns/100ps
`default_nettype none
module tb_ssb_core;
    import ssb_pkg::*;
    logic        clk, resetn, cyc, stb, we, ack, sck, miso, ss_n, mosi, irq;
    logic [3:0]  sel;
    logic [31:0] adr, wdat, rdat;
    logic [7:0]  q, b1, b2, r1, r2;
    logic [7:0]  mcfg [4] = '{8'h12, 8'h13, 8'h02, 8'h10};
    int          seed, num_errors, compares;
    ssb_core ssb_core_i (.CLK(clk), .RESETN(resetn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SCK(sck),
        .MISO(miso), .SS_N(ss_n), .MOSI(mosi), .IRQ(irq));
    ssb_slave_model ssb_slave_model_i (.SCK(sck), .MISO(miso), .SS_N(ss_n),
        .MOSI(mosi));
    // ----
    // Tasks
    // ----
    function automatic logic [7:0] st(logic rf, logic te, logic mf);
        return {rf, 1'b0, te, mf, 4'h0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] i,
                      input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {26'h0, i, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk);
        for (n = 0; n < 20 && ack !== 1'b1; n++)
            @(posedge clk);
        if (ack !== 1'b1)
            num_errors++;
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task end_of_test;
        $display("num_errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----
    // Clock, watchdog, sequence
    // ----
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run is about 4 us; generous margin
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        seed = 32'h4513a5f2;
        {resetn, cyc, stb, we, adr, wdat, num_errors, compares} = '0;
        sel = 4'h1;
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        r1 = 8'($random(seed));
        r2 = 8'($random(seed));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wb(1'b1, ADR_DATA, b1, q);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk(q, st(1'b0, 1'b1, 1'b0));
        wb(1'b0, ADR_DATA, 8'h00, q);
        chk(q, BYTE_ZERO);
        wb(1'b1, ADR_STATUS, 8'hff, q);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk(q, st(1'b0, 1'b1, 1'b0));
        wb(1'b0, 4'h7, 8'h00, q);
        chk(q, BYTE_ZERO);
        wb(1'b1, ADR_CTRL1, 8'h90, q);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        wb(1'b1, ADR_DATA, b1, q);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk(q, st(1'b0, 1'b1, 1'b0));
        wb(1'b1, ADR_DATA, b2, q);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk(q, st(1'b0, 1'b0, 1'b0));
        chk({7'h0, irq}, 8'h00);
        wb(1'b1, ADR_IRQ_ST, 8'h0f, q);
        ssb_slave_model_i.xfer(r1);
        repeat (6) @(posedge clk);
        chk(ssb_slave_model_i.got, b1);
        wb(1'b0, ADR_DATA, 8'h00, q);
        chk(q, r1);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk(q, st(1'b1, 1'b1, 1'b0));
        ssb_slave_model_i.xfer(r2);
        repeat (6) @(posedge clk);
        chk(ssb_slave_model_i.got, b2);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        wb(1'b0, ADR_DATA, 8'h00, q);
        chk(q, r1);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk(q, st(1'b0, 1'b1, 1'b0));
        wb(1'b0, ADR_IRQ_ST, 8'h00, q);
        chk({7'h0, q[EV_OVR]}, 8'h01);
        wb(1'b1, ADR_CTRL1, mcfg[0], q);
        ssb_slave_model_i.select(1'b1);
        repeat (4) @(posedge clk);
        ssb_slave_model_i.select(1'b0);
        repeat (4) @(posedge clk);
        wb(1'b1, ADR_CTRL1, mcfg[0], q);
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk({7'h0, q[ST_MODE_FAULT_FLAG]}, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, ADR_CTRL1, mcfg[i], q);
            ssb_slave_model_i.select(1'b1);
            repeat (8) @(posedge clk);
            wb(1'b0, ADR_STATUS, 8'h00, q);
            chk({7'h0, q[ST_MODE_FAULT_FLAG]}, {7'h0, i == 0});
            ssb_slave_model_i.select(1'b0);
            repeat (4) @(posedge clk);
            wb(1'b1, ADR_CTRL1, 8'h00, q);
            wb(1'b0, ADR_STATUS, 8'h00, q);
            chk({7'h0, q[ST_MODE_FAULT_FLAG]}, 8'h00);
        end
        wb(1'b1, ADR_IRQ_MSK, 8'h04, q);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        wb(1'b1, ADR_IRQ_ST, 8'h04, q);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wb(1'b0, ADR_STATUS, 8'h00, q);
        chk(q, st(1'b0, 1'b1, 1'b0));
        wb(1'b0, ADR_DATA, 8'h00, q);
        chk(q, BYTE_ZERO);
        end_of_test();
    end
endmodule // tb_ssb_core
`default_nettype wire
